// file: rtl/sob_bypass.sv
// Operational bypass logic of one scram protection cabinet.
// Assumes plant inputs synchronous to clk_sys and an AHB-Lite master.
//
// Behaviour
// RQ1: Turbine valve trips masked below low power
// RQ2: Enough bypass valves open in window masks
// RQ3: Low power mask drops above setpoint automatically
// RQ4: Turbine valve bypass shown in control room
// RQ5: Header pressure bypass only Shutdown or Refuel
// RQ6: Per division manual header pressure bypass switch
// RQ7: Header bypass gives rod block and indication
// RQ8: Startup or Run cancels header bypass
// RQ9: Alarm if header switch set in Startup/Run
// RQ10: Steam valve trip masked at low pressure; code masks it only outside Run
// RQ11: Four line switches mask closed valve trips
// RQ12: Bus loss trip masked except in Run
// RQ13: Shutdown entry scrams, bypassed after ten seconds
// RQ14: Run masks startup monitor trips and blocks
// RQ15: Run forces neutron monitoring coincident mode
// RQ16: Alarm on non-coincident switch in Run
// RQ17: Non-coincident division trips on any single trip
// RQ18: Vessel level high trip masked except Run
// RQ19: Condenser pressure trip masked except Run
// RQ20: Checks run always, never mask or scram
// RQ21: Invalid mode selector reading treated as Run
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module sob_bypass
#(
  parameter int unsigned ND          = sob_pkg::NUM_DIV,
  parameter int unsigned NL          = sob_pkg::NUM_LINE,
  parameter int unsigned NT          = sob_pkg::NUM_TBV,
  parameter int unsigned NS          = sob_pkg::NUM_STARTUP_RANGE_MONITOR,
  parameter int unsigned SD_DELAY    = sob_pkg::SD_DELAY_CYC,
  parameter int unsigned TBV_WINDOW  = sob_pkg::TBV_WIN_CYC
)
(
  // Clock, reset, enable
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 ce,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Mode selector, one-hot {run, startup, refuel, shutdown}
  input  wire logic [3:0]           mode_sel,
  // Turbine valves
  input  wire logic [7:0]           power_pct,
  input  wire logic [NT*8-1:0]      tbv_pos,
  input  wire logic                 tsv_trip_in,
  input  wire logic                 tcv_trip_in,
  output logic                      tsv_trip_out,
  output logic                      tcv_trip_out,
  output logic                      turb_byp_ind,
  // Accumulator header pressure
  input  wire logic [ND-1:0]        hdr_trip_in,
  input  wire logic [ND-1:0]        hdr_byp_sw,
  output logic [ND-1:0]             hdr_trip_out,
  output logic [ND-1:0]             hdr_byp_ind,
  output logic [ND-1:0]             rod_wd_block,
  output logic                      hdr_sw_alarm,
  // Steam isolation valves
  input  wire logic [ND-1:0]        siv_low_press,
  input  wire logic [NL-1:0]        siv_line_closed,
  input  wire logic [NL-1:0]        siv_line_sw,
  output logic [ND-1:0]             siv_trip_out,
  output logic [ND-1:0]             siv_byp_ind,
  output logic [NL-1:0]             line_byp_ind,
  // Bus loss, level, condenser
  input  wire logic                 bus_loss_in,
  input  wire logic                 level_hi_in,
  input  wire logic                 cond_hi_in,
  output logic                      bus_loss_out,
  output logic                      level_hi_out,
  output logic                      cond_hi_out,
  output logic                      mode_byp_ind,
  // Mode shutdown scram
  output logic                      mode_scram,
  output logic                      sd_byp_ind,
  // Neutron monitoring
  input  wire logic [NS-1:0]        startup_range_monitor_trip_in,
  input  wire logic [ND-1:0]        noncoinc_sw,
  input  wire logic                 startup_range_monitor_block_in,
  output logic [ND-1:0]             startup_range_monitor_div_trip,
  output logic                      startup_range_monitor_block_out,
  output logic [ND-1:0]             nms_coinc,
  output logic                      noncoinc_alarm,
  // Channel check
  output logic                      chk_fault
);

  ////////////////////////////////////////////////////////////////////////
  // Mode decoding
  function automatic sob_pkg::sob_mode_e decode_mode(input logic [3:0] s);
    sob_pkg::sob_mode_e m;
    m = sob_pkg::MODE_RUN;
    unique case (s)
      4'h1:    m = sob_pkg::MODE_SD;
      4'h2:    m = sob_pkg::MODE_RF;
      4'h4:    m = sob_pkg::MODE_SU;
      default: m = sob_pkg::MODE_RUN;
    endcase
    return m;
  endfunction

  sob_pkg::sob_mode_e mode;
  logic               mode_bad;
  logic               in_sd;
  logic               in_rf;
  logic               in_su;
  logic               in_run;

  assign mode     = decode_mode(mode_sel);                 // [RQ21]
  assign mode_bad = !(mode_sel inside {4'h1, 4'h2, 4'h4, 4'h8});
  assign in_sd    = (mode == sob_pkg::MODE_SD);
  assign in_rf    = (mode == sob_pkg::MODE_RF);
  assign in_su    = (mode == sob_pkg::MODE_SU);
  assign in_run   = (mode == sob_pkg::MODE_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  setpt;
  logic [7:0]  tbv_req;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_ok;
  logic        take;
  logic [31:0] rd_word;
  logic [31:0] byp_word;
  logic [31:0] trip_word;
  logic [31:0] alarm_word;

  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign take      = ce && hready && hsel &&
                     (htrans == sob_pkg::HTRANS_NONSEQ);
  assign addr_ok   = (haddr[31:8] == 24'h00_0000);

  ////////////////////////////////////////////////////////////////////////
  // Turbine valve trips
  logic [NT-1:0] tbv_open;
  logic [7:0]    tbv_cnt;
  logic          low_pwr;
  logic          turb_raw;
  logic          turb_raw_q;
  logic          win_act;
  logic [31:0]   win_cnt;
  logic          tbv_byp;
  logic          turb_mask;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_tbv
      assign tbv_open[gi] = (tbv_pos[gi*8 +: 8] >= sob_pkg::TBV_OPEN_PCT);
    end
  endgenerate

  always_comb
  begin
    tbv_cnt = 8'h00;
    for (int i = 0; i < NT; i++)
      tbv_cnt = tbv_cnt + 8'(tbv_open[i]);
  end

  assign low_pwr   = (power_pct < setpt);                  // [RQ1] [RQ3]
  assign turb_raw  = tsv_trip_in || tcv_trip_in;
  // Edge term holds trips off before the window flag rises
  assign turb_mask = low_pwr || tbv_byp || win_act ||      // [RQ2]
                     (turb_raw && !turb_raw_q);

  ////////////////////////////////////////////////////////////////////////
  // Header pressure, steam isolation, mode scram, monitors
  logic          hdr_permit;
  logic [ND-1:0] hdr_byp;
  logic [ND-1:0] siv_byp;
  logic          siv_line_trip;
  logic          sd_prev;
  logic [31:0]   sd_cnt;
  logic          sd_done;
  logic [7:0]    startup_range_monitor_cnt;
  logic          startup_range_monitor_any;
  logic          startup_range_monitor_coinc;
  logic [ND-1:0] coinc_eff;

  assign hdr_permit = in_sd || in_rf;                      // [RQ5] [RQ8]
  assign hdr_byp    = hdr_byp_sw & {ND{hdr_permit}};       // [RQ6]
  assign siv_byp    = siv_low_press & {ND{!in_run}};       // [RQ10]
  assign siv_line_trip = |(siv_line_closed & ~siv_line_sw); // [RQ11]
  assign sd_done    = (sd_cnt >= SD_DELAY);                // [RQ13]

  always_comb
  begin
    startup_range_monitor_cnt = 8'h00;
    for (int i = 0; i < NS; i++)
      startup_range_monitor_cnt = startup_range_monitor_cnt + 8'(startup_range_monitor_trip_in[i]);
  end

  assign startup_range_monitor_any   = (startup_range_monitor_cnt != 8'h00);
  assign startup_range_monitor_coinc = (startup_range_monitor_cnt >= sob_pkg::COINC_MIN);
  assign coinc_eff  = ~noncoinc_sw | {ND{in_run}};         // [RQ15]

  ////////////////////////////////////////////////////////////////////////
  // Next output values
  logic          next_tsv;
  logic          next_tcv;
  logic          next_turb_ind;
  logic [ND-1:0] next_hdr_trip;
  logic          next_hdr_alarm;
  logic [ND-1:0] next_siv_trip;
  logic          next_bus;
  logic          next_level;
  logic          next_cond;
  logic          next_mode_scram;
  logic          next_sd_ind;
  logic [ND-1:0] next_startup_range_monitor;
  logic          next_nc_alarm;

  assign next_tsv       = tsv_trip_in && !turb_mask;       // [RQ1] [RQ2]
  assign next_tcv       = tcv_trip_in && !turb_mask;       // [RQ1] [RQ2]
  assign next_turb_ind  = low_pwr || tbv_byp;              // [RQ4]
  assign next_hdr_trip  = hdr_trip_in & ~hdr_byp;          // [RQ6]
  assign next_hdr_alarm = (|hdr_byp_sw) && (in_su || in_run); // [RQ9]
  assign next_siv_trip  = {ND{siv_line_trip}} & ~siv_byp;  // [RQ10]
  assign next_bus       = bus_loss_in && in_run;           // [RQ12]
  assign next_level     = level_hi_in && in_run;           // [RQ18]
  assign next_cond      = cond_hi_in && in_run;            // [RQ19]
  assign next_mode_scram = in_sd && !sd_done;              // [RQ13]
  assign next_sd_ind    = in_sd && sd_done;                // [RQ13]
  assign next_nc_alarm  = in_run && (|noncoinc_sw);        // [RQ16]

  generate
    for (gi = 0; gi < ND; gi++)
    begin : g_div
      assign next_startup_range_monitor[gi] = !in_run &&                    // [RQ14]
        (coinc_eff[gi] ? startup_range_monitor_coinc : startup_range_monitor_any);           // [RQ17]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Status words
  assign byp_word = {12'h000,
                     siv_line_sw,
                     siv_byp,
                     hdr_byp,
                     !in_run,
                     sd_done && in_sd,
                     !in_run,
                     !in_run,
                     !in_run,
                     win_act,
                     tbv_byp,
                     low_pwr};
  assign trip_word = {12'h000,
                      startup_range_monitor_div_trip,
                      siv_trip_out,
                      hdr_trip_out,
                      cond_hi_out,
                      level_hi_out,
                      bus_loss_out,
                      mode_scram,
                      1'b0,
                      startup_range_monitor_block_out,
                      tcv_trip_out,
                      tsv_trip_out};
  assign alarm_word = {24'h00_0000,
                       mode_sel,
                       chk_fault,
                       noncoinc_alarm,
                       hdr_sw_alarm,
                       1'b0};

  always_comb
  begin
    unique case (haddr[7:0])
      sob_pkg::ADDR_SETPT:  rd_word = {24'h00_0000, setpt};
      sob_pkg::ADDR_TBVREQ: rd_word = {24'h00_0000, tbv_req};
      sob_pkg::ADDR_BYPASS: rd_word = byp_word;
      sob_pkg::ADDR_TRIP:   rd_word = trip_word;
      sob_pkg::ADDR_ALARM:  rd_word = alarm_word;
      default:              rd_word = sob_pkg::RD_ZERO;
    endcase
    if (!addr_ok)
      rd_word = sob_pkg::RD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus state
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hrdata  <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (ce)
    begin
      if (take && !hwrite)
        hrdata <= rd_word;
      wr_pend <= take && hwrite && addr_ok;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      setpt   <= sob_pkg::LOW_PWR_PCT;
      tbv_req <= sob_pkg::TBV_REQ_RST;
    end
    else if (ce && wr_pend)
    begin
      if (wr_addr == sob_pkg::ADDR_SETPT)
        setpt <= hwdata[7:0];
      if (wr_addr == sob_pkg::ADDR_TBVREQ)
        tbv_req <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bypass valve window
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      turb_raw_q <= 1'b0;
      win_act    <= 1'b0;
      win_cnt    <= 32'h0000_0000;
      tbv_byp    <= 1'b0;
    end
    else if (ce)
    begin
      turb_raw_q <= turb_raw;
      if (!turb_raw)
      begin
        win_act <= 1'b0;
        tbv_byp <= 1'b0;
      end
      else if (!turb_raw_q)
      begin
        win_act <= 1'b1;                                   // [RQ2]
        win_cnt <= 32'h0000_0000;
      end
      else if (win_act)
      begin
        if (tbv_cnt >= tbv_req)
        begin
          tbv_byp <= 1'b1;                                 // [RQ2]
          win_act <= 1'b0;
        end
        else if (win_cnt >= TBV_WINDOW - 1)
          win_act <= 1'b0;
        else
          win_cnt <= win_cnt + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shutdown delay
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sd_prev <= 1'b0;
      sd_cnt  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      sd_prev <= in_sd;
      // Count cleared outside Shutdown, no stale delay on entry
      if (!in_sd || !sd_prev)
        sd_cnt <= 32'h0000_0000;                           // [RQ13]
      else if (!sd_done)
        sd_cnt <= sd_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tsv_trip_out   <= 1'b0;
      tcv_trip_out   <= 1'b0;
      turb_byp_ind   <= 1'b0;
      hdr_trip_out   <= '0;
      hdr_byp_ind    <= '0;
      rod_wd_block   <= '0;
      hdr_sw_alarm   <= 1'b0;
      siv_trip_out   <= '0;
      siv_byp_ind    <= '0;
      line_byp_ind   <= '0;
      bus_loss_out   <= 1'b0;
      level_hi_out   <= 1'b0;
      cond_hi_out    <= 1'b0;
      mode_byp_ind   <= 1'b0;
      mode_scram     <= 1'b0;
      sd_byp_ind     <= 1'b0;
      startup_range_monitor_div_trip  <= '0;
      startup_range_monitor_block_out <= 1'b0;
      nms_coinc      <= '1;
      noncoinc_alarm <= 1'b0;
      chk_fault      <= 1'b0;
    end
    else if (ce)
    begin
      tsv_trip_out   <= next_tsv;
      tcv_trip_out   <= next_tcv;
      turb_byp_ind   <= next_turb_ind;                     // [RQ4]
      hdr_trip_out   <= next_hdr_trip;
      hdr_byp_ind    <= hdr_byp;                           // [RQ7]
      rod_wd_block   <= hdr_byp;                           // [RQ7]
      hdr_sw_alarm   <= next_hdr_alarm;
      siv_trip_out   <= next_siv_trip;
      siv_byp_ind    <= siv_byp;                           // [RQ10]
      line_byp_ind   <= siv_line_sw;                       // [RQ11]
      bus_loss_out   <= next_bus;
      level_hi_out   <= next_level;
      cond_hi_out    <= next_cond;
      mode_byp_ind   <= !in_run;                           // [RQ12]
      mode_scram     <= next_mode_scram;
      sd_byp_ind     <= next_sd_ind;
      startup_range_monitor_div_trip  <= next_startup_range_monitor;
      startup_range_monitor_block_out <= startup_range_monitor_block_in && !in_run;          // [RQ14]
      nms_coinc      <= coinc_eff;                         // [RQ15]
      noncoinc_alarm <= next_nc_alarm;
      chk_fault      <= mode_bad;                          // [RQ20]
    end
  end

endmodule

// file: include/sob_pkg.sv
// Constants, offsets and types of the operational bypass logic.
// Assumes a 100 MHz system clock and a single AHB-Lite slave port.
package sob_pkg;
  // Clock and timing
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned SD_DELAY_S    = 10;
  localparam int unsigned SD_DELAY_CYC  =
    32'(64'(SD_DELAY_S) * 64'd1_000_000_000 / 64'(CLK_NS));
  localparam int unsigned TBV_WIN_MS    = 500;
  localparam int unsigned TBV_WIN_CYC   =
    32'(64'(TBV_WIN_MS) * 64'd1_000_000 / 64'(CLK_NS));
  // Plant sizes and levels
  localparam int unsigned NUM_DIV       = 4;
  localparam int unsigned NUM_LINE      = 4;
  localparam int unsigned NUM_TBV       = 4;
  localparam int unsigned NUM_STARTUP_RANGE_MONITOR      = 4;
  localparam int unsigned PCT_W         = 8;
  localparam logic [7:0]  LOW_PWR_PCT   = 8'h28;
  localparam logic [7:0]  TBV_OPEN_PCT  = 8'h0A;
  localparam logic [7:0]  TBV_REQ_RST   = 8'h02;
  localparam logic [7:0]  COINC_MIN     = 8'h02;
  // Register byte offsets
  localparam logic [7:0]  ADDR_SETPT    = 8'h00;
  localparam logic [7:0]  ADDR_TBVREQ   = 8'h04;
  localparam logic [7:0]  ADDR_BYPASS   = 8'h08;
  localparam logic [7:0]  ADDR_TRIP     = 8'h0C;
  localparam logic [7:0]  ADDR_ALARM    = 8'h10;
  // Field positions of the bypass status word
  localparam int unsigned POS_HDR       = 8;
  localparam int unsigned POS_SIV       = 12;
  localparam int unsigned POS_LINE      = 16;
  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
  // Mode selector positions
  typedef enum logic [1:0] {
    MODE_SD,
    MODE_RF,
    MODE_SU,
    MODE_RUN
  } sob_mode_e;
endpackage

// file: dv/sob_bypass_properties.sv
// Checker of the operational bypass outputs, bound into sob_bypass.
// Assumes one clock domain and ce held high by the bench.
`timescale 1ns/1ps
module sob_bypass_properties
#(
  parameter int unsigned ND = 4,
  parameter int unsigned NL = 4
)
(
  // Clock and reset
  input logic          clk_sys,
  input logic          rst_b,
  // Plant inputs
  input logic [3:0]    mode_sel,
  input logic [7:0]    power_pct,
  input logic [ND-1:0] hdr_byp_sw,
  input logic [ND-1:0] noncoinc_sw,
  input logic [NL-1:0] siv_line_closed,
  input logic [NL-1:0] siv_line_sw,
  input logic          bus_loss_in,
  input logic          level_hi_in,
  input logic          cond_hi_in,
  // Plant outputs
  input logic          tsv_trip_out,
  input logic          tcv_trip_out,
  input logic          turb_byp_ind,
  input logic [ND-1:0] hdr_byp_ind,
  input logic [ND-1:0] rod_wd_block,
  input logic          hdr_sw_alarm,
  input logic [ND-1:0] siv_trip_out,
  input logic [ND-1:0] siv_byp_ind,
  input logic          bus_loss_out,
  input logic          level_hi_out,
  input logic          cond_hi_out,
  input logic          mode_byp_ind,
  input logic          mode_scram,
  input logic          sd_byp_ind,
  input logic [ND-1:0] startup_range_monitor_div_trip,
  input logic          startup_range_monitor_block_out,
  input logic [ND-1:0] nms_coinc,
  input logic          noncoinc_alarm
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Cycles spent in Shutdown
  logic [7:0] sd_cnt;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      sd_cnt <= 8'h00;
    else if (mode_sel != 4'b0001)
      sd_cnt <= 8'h00;
    else if (sd_cnt != 8'hFF)
      sd_cnt <= sd_cnt + 8'h01;
  ////////////////////////////////////////
  chk_low_pwr: assert property (rst_b && power_pct < 8'h14 |=>
    !tsv_trip_out && !tcv_trip_out && turb_byp_ind)
    else $error("turbine trips not masked at low power");
  chk_hdr_cancel: assert property ((mode_sel[2] || mode_sel[3]) |=>
    hdr_byp_ind == '0 && rod_wd_block == '0)
    else $error("header bypass outside Shutdown or Refuel");
  chk_hdr_follow: assert property (
    mode_sel == 4'b0010 |=>
    hdr_byp_ind == $past(hdr_byp_sw) && rod_wd_block == $past(hdr_byp_sw))
    else $error("header bypass or rod block wrong in Refuel");
  chk_hdr_alarm: assert property ((mode_sel[2] || mode_sel[3]) &&
    |hdr_byp_sw |=> hdr_sw_alarm)
    else $error("header switch alarm missing");
  chk_mode_mask: assert property (
    mode_sel == 4'b0100 |=>
    !bus_loss_out && !level_hi_out && !cond_hi_out && mode_byp_ind)
    else $error("mode trips not masked in Startup");
  chk_bad_mode: assert property (mode_sel == 4'b0000 |=>
    !mode_byp_ind &&
    {bus_loss_out, level_hi_out, cond_hi_out} ==
    $past({bus_loss_in, level_hi_in, cond_hi_in}))
    else $error("invalid mode not treated as Run");
  chk_run_coinc: assert property (
    mode_sel == 4'b1000 |=>
    nms_coinc == '1 && startup_range_monitor_div_trip == '0 && !startup_range_monitor_block_out &&
    noncoinc_alarm == |$past(noncoinc_sw))
    else $error("neutron monitoring wrong in Run");
  chk_siv_run: assert property (mode_sel == 4'b1000 |=>
    siv_byp_ind == '0 &&
    siv_trip_out == {ND{|$past(siv_line_closed & ~siv_line_sw)}})
    else $error("steam valve trip wrong in Run");
  chk_sd_scram: assert property (sd_cnt inside {[8'h02:8'h10]} |->
    mode_scram && !sd_byp_ind)
    else $error("no scram after entering Shutdown");
  chk_sd_bypass: assert property (sd_cnt > 8'h1E |->
    !mode_scram && sd_byp_ind)
    else $error("Shutdown scram not bypassed after delay");
  cover property (hdr_sw_alarm);
  cover property ($fell(mode_scram));
  cover property (noncoinc_alarm);
endmodule

bind sob_bypass sob_bypass_properties #(.ND(ND), .NL(NL)) u_chk (.*);

// file: dv/sob_tbv_model.sv
// Behavioural model of the turbine bypass valves.
// Assumes the bench commands how many valves open and after what lag.
`timescale 1ns/1ps
module sob_tbv_model
(
  // Clock and reset
  input  logic        clk_sys,
  input  logic        rst_b,
  // Command and positions
  input  logic [2:0]  open_cnt,
  input  logic [3:0]  lag,
  output logic [31:0] tbv_pos
);
  int t;
  always @(posedge clk_sys)
  begin
    t <= (!rst_b || open_cnt == 3'h0) ? 0 : (t < 15 ? t + 1 : t);
    for (int i = 0; i < 4; i++)
      tbv_pos[i*8+:8] <= (open_cnt > i && t >= lag) ? 8'h0C :
        8'($urandom % 10);
  end
endmodule

// file: dv/test_sob_bypass.sv
// Self-checking bench of sob_bypass with a reference model.
// Assumes short delay parameters and the valve model beside it.
`timescale 1ns/1ps
module test_sob_bypass;
  logic clk_sys, rst_b, ce, hsel, hwrite, hresp, hreadyout;
  logic tsv_trip_in, tcv_trip_in, bus_loss_in, level_hi_in, cond_hi_in;
  logic startup_range_monitor_block_in, tsv_trip_out, tcv_trip_out, turb_byp_ind;
  logic hdr_sw_alarm, bus_loss_out, level_hi_out, cond_hi_out;
  logic mode_byp_ind, mode_scram, sd_byp_ind, startup_range_monitor_block_out;
  logic noncoinc_alarm, chk_fault, run, sdrf, t;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, open_cnt;
  logic [7:0] power_pct;
  logic [3:0] mode_sel, hdr_trip_in, hdr_byp_sw, siv_low_press, lag;
  logic [3:0] siv_line_closed, siv_line_sw, startup_range_monitor_trip_in, noncoinc_sw;
  logic [3:0] hdr_trip_out, hdr_byp_ind, rod_wd_block, siv_trip_out;
  logic [3:0] siv_byp_ind, line_byp_ind, startup_range_monitor_div_trip, nms_coinc;
  logic [3:0] e_hdr, e_sb, e_sr;
  logic [3:0] modes [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h5};
  wire [31:0] tbv_pos;
  wire hready = hreadyout;
  int errors, n_compared, n;
  sob_bypass #(.SD_DELAY(20), .TBV_WINDOW(10)) uut (.*);
  sob_tbv_model u_tbv (.clk_sys(clk_sys), .rst_b(rst_b),
    .open_cnt(open_cnt), .lag(lag), .tbv_pos(tbv_pos));
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= sob_pkg::HTRANS_NONSEQ;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask
  task turb(input logic [7:0] p, input logic [2:0] oc, input logic [2:0] e);
    @(posedge clk_sys);
    mode_sel <= 4'h8;
    power_pct <= p;
    open_cnt <= oc;
    tsv_trip_in <= 1'b1;
    tcv_trip_in <= 1'b1;
    repeat (16) @(posedge clk_sys);
    #1 check("turbine", {tsv_trip_out, tcv_trip_out, turb_byp_ind}, e);
    @(posedge clk_sys);
    {tsv_trip_in, tcv_trip_in, open_cnt} <= 5'h00;
    repeat (3) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  initial
  begin
    #200000 errors++;
    end_sim();
  end
  initial
  begin
    {clk_sys, rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {tsv_trip_in, tcv_trip_in, power_pct, open_cnt} = '0;
    {hdr_trip_in, hdr_byp_sw, siv_low_press, siv_line_closed} = '0;
    {siv_line_sw, startup_range_monitor_trip_in, noncoinc_sw, startup_range_monitor_block_in} = '0;
    {bus_loss_in, level_hi_in, cond_hi_in, mode_sel} = 7'h08;
    {ce, hsize, lag} = 8'hA3;
    void'($urandom(32'hf20a127d));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
    check("setpoint", rd, 32'h0000_0028);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
    check("valve count", rd, 32'h0000_0002);
    bus(1'b1, 32'h0000_0020, 32'h0000_00FF, rd);
    bus(1'b0, 32'h0000_0020, 32'h0000_0000, rd);
    check("unmapped", rd, 32'h0000_0000);
    for (int k = 0; k < 80; k++)
    begin
      @(posedge clk_sys);
      mode_sel <= modes[$urandom % 6];
      power_pct <= 8'($urandom % 100);
      {hdr_trip_in, hdr_byp_sw, siv_low_press, siv_line_closed} <=
        16'($urandom);
      {siv_line_sw, startup_range_monitor_trip_in, noncoinc_sw} <= 12'($urandom);
      {bus_loss_in, level_hi_in, cond_hi_in, startup_range_monitor_block_in} <= 4'($urandom);
      repeat (2) @(posedge clk_sys);
      #1 run = !(mode_sel inside {4'h1, 4'h2, 4'h4});
      sdrf = mode_sel inside {4'h1, 4'h2};
      e_hdr = sdrf ? hdr_byp_sw : 4'h0;
      e_sb = run ? 4'h0 : siv_low_press;
      t = |(siv_line_closed & ~siv_line_sw);
      n = $countones(startup_range_monitor_trip_in);
      for (int i = 0; i < 4; i++)
        e_sr[i] = !run && (noncoinc_sw[i] ? n >= 1 : n >= 2);
      check("header", {hdr_byp_ind, rod_wd_block, hdr_trip_out, hdr_sw_alarm},
        {e_hdr, e_hdr, hdr_trip_in & ~e_hdr, !sdrf && |hdr_byp_sw});
      check("steam", {siv_trip_out, siv_byp_ind, line_byp_ind},
        {{4{t}} & ~e_sb, e_sb, siv_line_sw});
      check("mode", {bus_loss_out, level_hi_out, cond_hi_out, mode_byp_ind},
        {run & bus_loss_in, run & level_hi_in, run & cond_hi_in, !run});
      check("nms", {startup_range_monitor_div_trip, startup_range_monitor_block_out, nms_coinc, noncoinc_alarm},
        {e_sr, !run && startup_range_monitor_block_in, run ? 4'hF : ~noncoinc_sw,
        run && |noncoinc_sw});
      check("fault", {chk_fault, turb_byp_ind},
        {$countones(mode_sel) != 1, power_pct < 8'h28});
    end
    bus(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
    check("alarm mode", rd[7:4], mode_sel);
    turb(8'h27, 3'h0, 3'b001);
    turb(8'h28, 3'h0, 3'b110);
    turb(8'h29, 3'h1, 3'b110);
    turb(8'h29, 3'h2, 3'b001);
    bus(1'b1, 32'h0000_0000, 32'h0000_0032, rd);
    power_pct <= 8'h2D;
    bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
    check("setpoint", rd, 32'h0000_0032);
    check("low power", turb_byp_ind, 1'b1);
    bus(1'b1, 32'h0000_0000, 32'h0000_0028, rd);
    @(posedge clk_sys);
    mode_sel <= 4'h1;
    repeat (3) @(posedge clk_sys);
    #1 check("sd scram", {mode_scram, sd_byp_ind}, 2'b10);
    repeat (25) @(posedge clk_sys);
    #1 check("sd bypass", {mode_scram, sd_byp_ind}, 2'b01);
    repeat (8) @(posedge clk_sys);
    #1 check("sd hold", {mode_scram, sd_byp_ind}, 2'b01);
    end_sim();
  end
endmodule
